// ==== src/panel_io_pkg.sv ====
// package: register map, field layouts and reset values of the panel block
package panel_io_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] OFF_RGB      = 8'h00; // rgb lamp control, bits 2:0
  localparam logic [7:0] OFF_SEG_ONE  = 8'h04; // display one pattern
  localparam logic [7:0] OFF_SEG_TWO  = 8'h08; // display two pattern
  localparam logic [7:0] OFF_SEG_THR  = 8'h0c; // display three pattern
  localparam logic [7:0] OFF_UPDATE   = 8'h10; // write 1s: load displays
  localparam logic [7:0] OFF_BUTTON   = 8'h14; // sampled buttons, event byte
  localparam logic [7:0] OFF_IRQ_STAT = 8'h18; // sticky events, w1c
  localparam logic [7:0] OFF_IRQ_MASK = 8'h1c; // interrupt mask
  // rgb field positions
  localparam int RGB_RED   = 0;
  localparam int RGB_GREEN = 1;
  localparam int RGB_BLUE  = 2;
  // segment bit positions: a..g then decimal point
  localparam int SEG_A  = 0;
  localparam int SEG_DP = 7;
  // event byte values
  localparam logic [7:0] BUTTON_ASSERT_PATTERN = 8'ha5;
  localparam logic [7:0] BUTTON_IDLE_PATTERN   = 8'h00;
  // interrupt status bits
  localparam int IRQ_PRESS   = 0; // a button went down
  localparam int IRQ_RELEASE = 1; // both buttons back up
  localparam int IRQ_BITS    = 2;
  // reset values
  localparam logic [7:0] SEG_RESET = 8'h00;
  localparam logic [2:0] RGB_RESET = 3'h0;
  // timing: the block uses the bus clock only, one cycle per sample
  localparam int SAMPLE_CYCLES = 1;

  // pin group for one lamp bank: level driven and its enable
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] drive;
  } sink_pins_t;
endpackage

// ==== src/sink_driver.sv ====
// one bank of active-low current-sink pins loaded on an update enable
module sink_driver #(
  parameter int WIDTH = 8
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             update,   // load enable
  input  wire logic [WIDTH-1:0] pattern,  // set bit lights the lamp
  output logic      [WIDTH-1:0] sink_out, // always low when driven
  output logic      [WIDTH-1:0] sink_oe   // high pulls cathode to ground
);
  // a lit lamp is a driven low; an unlit lamp is a released pin, never high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sink_oe <= '0;
    end else if (update) begin
      sink_oe <= pattern;
    end
  end
  // the level never goes high, so a stray enable can only sink current
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sink_out <= '0;
    end else begin
      sink_out <= '0;
    end
  end
endmodule

// ==== src/button_sampler.sv ====
// samples the two push buttons every clock and builds the event byte
module button_sampler (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       button_one_in,  // active-low button
  input  wire logic       button_two_in,  // active-low button
  output logic [1:0]      sampled,        // registered pin levels
  output logic [7:0]      event_byte      // assert pattern or idle value
);
  // pins are taken as synchronous; one register stage per edge
  wire any_low = !button_one_in || !button_two_in;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sampled    <= 2'h3;
      event_byte <= panel_io_pkg::BUTTON_IDLE_PATTERN;
    end else begin
      sampled <= {button_two_in, button_one_in};
      event_byte <= any_low ? panel_io_pkg::BUTTON_ASSERT_PATTERN
                            : panel_io_pkg::BUTTON_IDLE_PATTERN;
    end
  end
endmodule

// ==== src/panel_io.sv ====
// top: apb registers, rgb lamp, three segment displays, push buttons
//
// Chosen here: the register addresses and the APB slave port.
module panel_io (
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // rgb lamp, open-drain sinks
  output logic             rgb_red_sink,
  output logic             rgb_red_sink_oe,
  output logic             rgb_green_sink,
  output logic             rgb_green_sink_oe,
  output logic             rgb_blue_sink,
  output logic             rgb_blue_sink_oe,
  // segment cathodes, bit 7 is decimal_point_segment
  output logic [7:0]       seg_one_sink,
  output logic [7:0]       seg_one_sink_oe,
  output logic [7:0]       seg_two_sink,
  output logic [7:0]       seg_two_sink_oe,
  output logic [7:0]       seg_thr_sink,
  output logic [7:0]       seg_thr_sink_oe,
  // push buttons, never driven
  input  wire logic        button_one_in,
  input  wire logic        button_two_in,
  output logic [7:0]       button_event,
  output logic             irq
);
  // software-visible registers
  logic [2:0]  rgb_ctl;      // set bit lights the channel
  logic [7:0]  seg_pat [3];  // per display pattern
  logic [2:0]  seg_update;   // one-cycle load pulses
  localparam int IRQ_W = panel_io_pkg::IRQ_BITS; // interrupt vector width
  logic [IRQ_W-1:0] irq_stat;  // sticky events
  logic [IRQ_W-1:0] irq_mask;  // enables

  // apb decode: single-wait-free slave, answers in the access phase
  wire access  = psel && penable;
  wire wr      = access && pwrite;
  wire hit_rgb = paddr == panel_io_pkg::OFF_RGB;
  wire hit_s1  = paddr == panel_io_pkg::OFF_SEG_ONE;
  wire hit_s2  = paddr == panel_io_pkg::OFF_SEG_TWO;
  wire hit_s3  = paddr == panel_io_pkg::OFF_SEG_THR;
  wire hit_upd = paddr == panel_io_pkg::OFF_UPDATE;
  wire hit_btn = paddr == panel_io_pkg::OFF_BUTTON;
  wire hit_ist = paddr == panel_io_pkg::OFF_IRQ_STAT;
  wire hit_imk = paddr == panel_io_pkg::OFF_IRQ_MASK;
  wire mapped  = hit_rgb || hit_s1 || hit_s2 || hit_s3 || hit_upd
              || hit_btn || hit_ist || hit_imk;

  // button sampling
  logic [1:0] btn_now;     // sampled levels, one per button
  logic [1:0] btn_prev;    // previous sample for edge events
  logic [7:0] next_event;  // event byte from the sampler
  button_sampler u_buttons (
    .pclk          (pclk),
    .presetn       (presetn),
    .button_one_in (button_one_in),
    .button_two_in (button_two_in),
    .sampled       (btn_now),
    .event_byte    (next_event)
  );

  // events: a press when some button first goes low, release when all up
  wire any_now   = !(&btn_now);
  wire any_prev  = !(&btn_prev);
  wire ev_press  = any_now && !any_prev;
  wire ev_rel    = !any_now && any_prev;
  wire [IRQ_W-1:0] ev_vec = {ev_rel, ev_press};
  wire [IRQ_W-1:0] w1c    = (wr && hit_ist) ? pwdata[IRQ_W-1:0] : '0;

  // read mux as named wires
  wire [31:0] rd_rgb = {29'h0, rgb_ctl};
  wire [31:0] rd_s1  = {24'h0, seg_pat[0]};
  wire [31:0] rd_s2  = {24'h0, seg_pat[1]};
  wire [31:0] rd_s3  = {24'h0, seg_pat[2]};
  wire [31:0] rd_btn = {22'h0, btn_now, next_event};
  wire [31:0] rd_ist = {30'h0, irq_stat};
  wire [31:0] rd_imk = {30'h0, irq_mask};
  wire [31:0] next_rdata = hit_rgb ? rd_rgb :
                           hit_s1  ? rd_s1  :
                           hit_s2  ? rd_s2  :
                           hit_s3  ? rd_s3  :
                           hit_btn ? rd_btn :
                           hit_ist ? rd_ist :
                           hit_imk ? rd_imk : 32'h0;

  // bus answer: pready and data registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= (psel && !penable && !pwrite) ? next_rdata : 32'h0;
    end
  end

  // writes land only on the completing access edge
  wire wr_ok = wr && pready;

  // control registers; pattern bit order shared with software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rgb_ctl    <= panel_io_pkg::RGB_RESET;
      seg_pat[0] <= panel_io_pkg::SEG_RESET;
      seg_pat[1] <= panel_io_pkg::SEG_RESET;
      seg_pat[2] <= panel_io_pkg::SEG_RESET;
      irq_mask   <= '0;
    end else begin
      if (wr_ok && hit_rgb) rgb_ctl    <= pwdata[2:0];
      if (wr_ok && hit_s1)  seg_pat[0] <= pwdata[7:0];
      if (wr_ok && hit_s2)  seg_pat[1] <= pwdata[7:0];
      if (wr_ok && hit_s3)  seg_pat[2] <= pwdata[7:0];
      if (wr_ok && hit_imk) irq_mask   <= pwdata[IRQ_W-1:0];
    end
  end

  // update strobes: one cycle after the write, so patterns written in the
  // same bus transfer order are already stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg_update <= 3'h0;
    end else begin
      seg_update <= (wr_ok && hit_upd) ? pwdata[2:0] : 3'h0;
    end
  end

  // sticky status: a new event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
      btn_prev <= 2'h3;
      irq      <= 1'b0;
    end else begin
      btn_prev <= btn_now;
      irq_stat <= (irq_stat & ~(wr_ok ? w1c : '0)) | ev_vec;
      irq      <= |(((irq_stat & ~(wr_ok ? w1c : '0)) | ev_vec) & irq_mask);
    end
  end

  // event byte output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      button_event <= panel_io_pkg::BUTTON_IDLE_PATTERN;
    end else begin
      button_event <= next_event;
    end
  end

  // rgb: each channel its own pin, follows its control bit directly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rgb_red_sink_oe   <= 1'b0;
      rgb_green_sink_oe <= 1'b0;
      rgb_blue_sink_oe  <= 1'b0;
    end else begin
      rgb_red_sink_oe   <= rgb_ctl[panel_io_pkg::RGB_RED];
      rgb_green_sink_oe <= rgb_ctl[panel_io_pkg::RGB_GREEN];
      rgb_blue_sink_oe  <= rgb_ctl[panel_io_pkg::RGB_BLUE];
    end
  end
  // released channels float; level is ground whenever enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rgb_red_sink   <= 1'b0;
      rgb_green_sink <= 1'b0;
      rgb_blue_sink  <= 1'b0;
    end else begin
      rgb_red_sink   <= 1'b0;
      rgb_green_sink <= 1'b0;
      rgb_blue_sink  <= 1'b0;
    end
  end

  // three display banks
  sink_driver #(.WIDTH(8)) u_seg_one (
    .pclk     (pclk),
    .presetn  (presetn),
    .update   (seg_update[0]),
    .pattern  (seg_pat[0]),
    .sink_out (seg_one_sink),
    .sink_oe  (seg_one_sink_oe)
  );
  sink_driver #(.WIDTH(8)) u_seg_two (
    .pclk     (pclk),
    .presetn  (presetn),
    .update   (seg_update[1]),
    .pattern  (seg_pat[1]),
    .sink_out (seg_two_sink),
    .sink_oe  (seg_two_sink_oe)
  );
  sink_driver #(.WIDTH(8)) u_seg_thr (
    .pclk     (pclk),
    .presetn  (presetn),
    .update   (seg_update[2]),
    .pattern  (seg_pat[2]),
    .sink_out (seg_thr_sink),
    .sink_oe  (seg_thr_sink_oe)
  );

  // checks: each display bank moves only on its own update pulse
  seg_hold_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    !seg_update[0] |=> $stable(seg_one_sink_oe))
    else $error("display one changed without update");
  seg_load_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    seg_update[0] |=> seg_one_sink_oe == $past(seg_pat[0]))
    else $error("display one did not load pattern");
  two_hold_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    !seg_update[1] |=> $stable(seg_two_sink_oe))
    else $error("display two changed without update");
  two_load_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    seg_update[1] |=> seg_two_sink_oe == $past(seg_pat[1]))
    else $error("display two did not load pattern");
  thr_hold_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    !seg_update[2] |=> $stable(seg_thr_sink_oe))
    else $error("display three changed without update");
  thr_load_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    seg_update[2] |=> seg_thr_sink_oe == $past(seg_pat[2]))
    else $error("display three did not load pattern");
  update_idle_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    !(wr_ok && hit_upd) |=> seg_update == 3'h0)
    else $error("update pulse without update write");
  pattern_hold_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    !(wr_ok && hit_s1) |=> $stable(seg_pat[0]))
    else $error("display one pattern changed without write");
  // checks: cathode and rgb levels never go high, only the enables move
  seg_level_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    seg_two_sink == 8'h00 && seg_thr_sink == 8'h00)
    else $error("segment cathode driven high");
  one_level_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    seg_one_sink == 8'h00)
    else $error("display one cathode driven high");
  rgb_level_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    !rgb_red_sink && !rgb_green_sink && !rgb_blue_sink)
    else $error("rgb pin driven high");
  rgb_follow_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    ##1 rgb_blue_sink_oe == $past(rgb_ctl[2]))
    else $error("blue channel not following control");
  red_follow_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    ##1 rgb_red_sink_oe == $past(rgb_ctl[0]))
    else $error("red channel not following control");
  green_follow_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    ##1 rgb_green_sink_oe == $past(rgb_ctl[1]))
    else $error("green channel not following control");
  rgb_hold_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    !(wr_ok && hit_rgb) |=> $stable(rgb_ctl))
    else $error("rgb control changed without write");
  // checks: button sampling and the event byte
  btn_assert_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    !button_one_in |-> ##2 button_event == 8'ha5)
    else $error("assert pattern missing after press");
  btn_two_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    !button_two_in |-> ##2 button_event == 8'ha5)
    else $error("assert pattern missing after second press");
  btn_idle_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    (button_one_in && button_two_in) |-> ##2 button_event == 8'h00)
    else $error("idle value missing with buttons up");
  event_legal_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    button_event == panel_io_pkg::BUTTON_ASSERT_PATTERN
    || button_event == panel_io_pkg::BUTTON_IDLE_PATTERN)
    else $error("event byte neither assert nor idle value");
  btn_sample_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    ##1 btn_now == $past({button_two_in, button_one_in}))
    else $error("buttons not sampled every edge");
  // checks: apb answers in the first access cycle and only then
  ready_timing_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    (psel && !penable) |=> pready)
    else $error("ready missing in first access cycle");
  ready_only_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    !(psel && !penable) |=> !pready)
    else $error("ready without a setup cycle");
  slverr_pair_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    pslverr |-> pready)
    else $error("slave error without ready");
  slverr_mapped_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    (psel && !penable && mapped) |=> !pslverr)
    else $error("slave error on a mapped register");
  rdata_write_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    (psel && !penable && pwrite) |=> prdata == 32'h0)
    else $error("read data not zero on a write");
  rdata_idle_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    !(psel && !penable) |=> prdata == 32'h0)
    else $error("read data not zero outside access");
  // checks: sticky status, set beats clear, level interrupt
  stat_sticky_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    !(wr_ok && hit_ist) |=>
    (irq_stat & $past(irq_stat)) == $past(irq_stat))
    else $error("status bit lost without clear");
  press_set_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    ev_press |=> irq_stat[panel_io_pkg::IRQ_PRESS])
    else $error("press event not recorded");
  release_set_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    ev_rel |=> irq_stat[panel_io_pkg::IRQ_RELEASE])
    else $error("release event not recorded");
  clear_w1c_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    (wr_ok && w1c[panel_io_pkg::IRQ_PRESS] && !ev_press)
    |=> !irq_stat[panel_io_pkg::IRQ_PRESS])
    else $error("press status not cleared by write");
  irq_level_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    ##1 irq == |(irq_stat & $past(irq_mask)))
    else $error("interrupt not following masked status");
  // checks: reset releases every lamp pin, so no disable here
  pin_reset_a: assert property (@(posedge pclk)
    !presetn |-> seg_one_sink_oe == 8'h00 && seg_two_sink_oe == 8'h00
    && seg_thr_sink_oe == 8'h00 && !rgb_red_sink_oe
    && !rgb_green_sink_oe && !rgb_blue_sink_oe)
    else $error("lamp pin driven during reset");
endmodule

// ==== tb/panel_far_side.sv ====
// far side model: lamps hung from the anode rail, buttons with pull-ups
module panel_far_side (
  input  wire logic [2:0]  rgb_sink,      // rgb cathode levels
  input  wire logic [2:0]  rgb_oe,        // rgb cathode enables
  input  wire logic [23:0] seg_sink,      // three displays, cathode levels
  input  wire logic [23:0] seg_oe,        // three displays, enables
  input  wire logic [1:0]  press,         // bench holds a button down
  output logic      [2:0]  rgb_lit,       // lamp glows
  output logic      [23:0] seg_lit,       // segment glows
  output logic             button_one_in, // contact, pulled up when open
  output logic             button_two_in  // contact, pulled up when open
);
  timeunit 1ns;
  timeprecision 1ps;
  // a released cathode floats to the rail, so only a driven low lights
  assign rgb_lit = rgb_oe & ~rgb_sink;
  // same current-sink wiring for every segment of every display
  assign seg_lit = seg_oe & ~seg_sink;
  // closed contact pulls to ground, open one rests high
  assign button_one_in = ~press[0];
  assign button_two_in = ~press[1];
endmodule

// ==== tb/testbench.sv ====
// self-checking bench: apb host, lamps and buttons around the panel block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, button_event;
  logic [31:0] pwdata, prdata, rd;
  logic        irq, err;
  wire         b1, b2;        // contacts from the far side
  wire  [2:0]  rgb_sink, rgb_oe, rgb_lit;
  wire  [23:0] seg_sink, seg_oe, seg_lit;
  logic [1:0]  press;         // buttons held by the bench
  int          error_cnt;     // mismatches
  int          compares;      // comparisons made

  panel_io uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .rgb_red_sink(rgb_sink[0]), .rgb_red_sink_oe(rgb_oe[0]),
    .rgb_green_sink(rgb_sink[1]), .rgb_green_sink_oe(rgb_oe[1]),
    .rgb_blue_sink(rgb_sink[2]), .rgb_blue_sink_oe(rgb_oe[2]),
    .seg_one_sink(seg_sink[7:0]), .seg_one_sink_oe(seg_oe[7:0]),
    .seg_two_sink(seg_sink[15:8]), .seg_two_sink_oe(seg_oe[15:8]),
    .seg_thr_sink(seg_sink[23:16]), .seg_thr_sink_oe(seg_oe[23:16]),
    .button_one_in(b1), .button_two_in(b2),
    .button_event(button_event), .irq(irq)
  );

  panel_far_side far (
    .rgb_sink(rgb_sink), .rgb_oe(rgb_oe), .seg_sink(seg_sink),
    .seg_oe(seg_oe), .press(press), .rgb_lit(rgb_lit), .seg_lit(seg_lit),
    .button_one_in(b1), .button_two_in(b2)
  );

  // 25 MHz bus clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // single place where the run ends
  task automatic complete_run();
    $display("checks %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // case equality so an unknown never passes
  task automatic chk(input string what, input logic [31:0] exp, got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // one apb transfer; a spare edge first keeps back-to-back calls race-free
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // the slave decides the wait; pready or the 16-edge bound ends it
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      chk("pready", 32'h1, 32'h0);
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // main sequence
  initial begin
    error_cnt = 0;
    compares = 0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    press = 2'b00;
    presetn = 1'b0;
    tick(7);
    chk("reset lit", 32'h0, 32'({rgb_lit, seg_lit}));
    chk("reset oe", 32'h0, 32'({rgb_oe, seg_oe}));
    chk("reset event", 32'h0, 32'(button_event));
    tick(1);
    presetn <= 1'b1;
    // every colour combination
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, panel_io_pkg::OFF_RGB, 32'(i));
      tick(2);
      chk("rgb lit", 32'(i), 32'(rgb_lit));
      chk("rgb oe", 32'(i), 32'(rgb_oe));
    end
    apb(1'b1, panel_io_pkg::OFF_SEG_ONE, 32'h81);
    apb(1'b1, panel_io_pkg::OFF_SEG_TWO, 32'h7e);
    apb(1'b1, panel_io_pkg::OFF_SEG_THR, 32'h5a);
    tick(3);
    chk("seg hold", 32'h0, 32'(seg_lit));
    apb(1'b1, panel_io_pkg::OFF_UPDATE, 32'h5);
    tick(3);
    chk("seg one three", 32'h5a0081, 32'(seg_lit));
    apb(1'b1, panel_io_pkg::OFF_UPDATE, 32'h2);
    tick(3);
    chk("seg all", 32'h5a7e81, 32'(seg_lit));
    chk("sinks low", 32'h0, 32'({rgb_sink, seg_sink}));
    // pattern read back keeps the software bit order
    apb(1'b0, panel_io_pkg::OFF_SEG_TWO, 32'h0);
    chk("seg two read", 32'h7e, rd);
    // unmapped place refused
    apb(1'b0, 8'h20, 32'h0);
    chk("slverr", 32'h1, 32'(err));
    chk("unmapped read", 32'h0, rd);
    // press with interrupt masked, then unmask and clear
    press <= 2'b01;
    tick(3);
    chk("event one", 32'ha5, 32'(button_event));
    apb(1'b0, panel_io_pkg::OFF_BUTTON, 32'h0);
    chk("button reg", 32'h2a5, rd);
    chk("irq masked", 32'h0, 32'(irq));
    apb(1'b0, panel_io_pkg::OFF_IRQ_STAT, 32'h0);
    chk("status press", 32'h1, rd);
    apb(1'b1, panel_io_pkg::OFF_IRQ_MASK, 32'h1);
    tick(2);
    chk("irq on", 32'h1, 32'(irq));
    apb(1'b1, panel_io_pkg::OFF_IRQ_STAT, 32'h1);
    tick(2);
    chk("irq cleared", 32'h0, 32'(irq));
    press <= 2'b00;
    tick(3);
    chk("event idle", 32'h0, 32'(button_event));
    apb(1'b0, panel_io_pkg::OFF_IRQ_STAT, 32'h0);
    chk("status release", 32'h2, rd);
    chk("irq release masked", 32'h0, 32'(irq));
    press <= 2'b10;
    tick(3);
    chk("event two", 32'ha5, 32'(button_event));
    chk("irq second press", 32'h1, 32'(irq));
    apb(1'b0, panel_io_pkg::OFF_BUTTON, 32'h0);
    chk("button reg two", 32'h1a5, rd);
    complete_run();
  end
endmodule
